// ==== src/isx_core.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Increment-skip reads file register, adds one
// - Destination bit picks W or file
// - Nonzero result discards prefetched instruction, NOP
// - Two-word skipped instruction adds another NOP
// - Access bit selects access bank or banked
// - Extended set, a clear, f<=5Fh: indexed
// - OR literal into W, update N, Z
module isx_core (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] instr_i,
  input wire logic next_two_word_i,
  input wire logic ext_set_en_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [7:0] file_rdata_i,
  output isx_pkg::isx_file_addr_type file_raddr_o,
  output isx_pkg::isx_file_wr_type file_wr_o,
  output logic [7:0] w_o,
  output logic neg_flag_o,
  output logic zero_flag_o,
  output logic [1:0] phase_o,
  output logic nop_cycle_o,
  output logic instr_done_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  isx_pkg::isx_phase_type phase_q, phase_d;
  isx_pkg::isx_flow_type flow_q, flow_d;
  logic [15:0] ir_q, ir_d;
  logic [7:0] opnd_q, opnd_d;
  logic [7:0] res_q, res_d;
  logic [7:0] w_q, w_d;
  logic n_q, n_d;
  logic z_q, z_d;
  logic two_word_q, two_word_d;
  isx_pkg::isx_file_wr_type wr_q, wr_d;
  isx_pkg::isx_file_addr_type addr_s;
  logic is_inc, is_or;

  isx_addr_gen u_addr (
    .file_i(ir_q[7:0]),
    .access_bit_i(ir_q[isx_pkg::ACCESS_BIT]),
    .ext_set_en_i(ext_set_en_i),
    .bank_select_register_i(bank_select_register_i),
    .addr_o(addr_s)
  );

  assign is_inc = (flow_q == isx_pkg::ISX_RUN) &&
                  (ir_q[isx_pkg::OPC_HI:isx_pkg::OPC6_LO] == isx_pkg::OP_INC_SKIP_NZ);
  assign is_or = (flow_q == isx_pkg::ISX_RUN) &&
                 (ir_q[isx_pkg::OPC_HI:isx_pkg::OPC8_LO] == isx_pkg::OP_OR_LITERAL);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    phase_d = phase_q;
    flow_d = flow_q;
    ir_d = ir_q;
    opnd_d = opnd_q;
    res_d = res_q;
    w_d = w_q;
    n_d = n_q;
    z_d = z_q;
    two_word_d = two_word_q;
    wr_d = wr_q;
    wr_d.we = 1'b0;
    case (phase_q)
      isx_pkg::ISX_DECODE: begin
        ir_d = instr_i;
        two_word_d = next_two_word_i;
        phase_d = isx_pkg::ISX_READ;
      end
      isx_pkg::ISX_READ: begin
        if (is_inc) begin
          opnd_d = file_rdata_i;
        end else begin
          opnd_d = ir_q[7:0];
        end
        phase_d = isx_pkg::ISX_PROCESS;
      end
      isx_pkg::ISX_PROCESS: begin
        if (is_inc) begin
          res_d = opnd_q + isx_pkg::ONE;
        end else begin
          res_d = w_q | opnd_q;
        end
        phase_d = isx_pkg::ISX_WRITE;
      end
      isx_pkg::ISX_WRITE: begin
        phase_d = isx_pkg::ISX_DECODE;
        flow_d = isx_pkg::ISX_RUN;
        if (is_inc) begin
          if (ir_q[isx_pkg::DEST_BIT]) begin
            wr_d.we = 1'b1;
            wr_d.addr = addr_s.addr;
            wr_d.data = res_q;
          end else begin
            w_d = res_q;
          end
          if (res_q != isx_pkg::ZERO) begin
            flow_d = isx_pkg::ISX_FLUSH1;
          end
        end else if (is_or) begin
          w_d = res_q;
          n_d = res_q[7];
          z_d = (res_q == isx_pkg::ZERO);
        end else if (flow_q == isx_pkg::ISX_FLUSH1 && two_word_q) begin
          flow_d = isx_pkg::ISX_FLUSH2;
        end
      end
      default: begin
        phase_d = isx_pkg::ISX_DECODE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= isx_pkg::ISX_DECODE;
      flow_q <= isx_pkg::ISX_RUN;
      ir_q <= 16'h0000;
      opnd_q <= isx_pkg::ZERO;
      res_q <= isx_pkg::ZERO;
      w_q <= isx_pkg::W_RESET;
      n_q <= 1'b0;
      z_q <= 1'b0;
      two_word_q <= 1'b0;
      wr_q <= '0;
    end else begin
      phase_q <= phase_d;
      flow_q <= flow_d;
      ir_q <= ir_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      w_q <= w_d;
      n_q <= n_d;
      z_q <= z_d;
      two_word_q <= two_word_d;
      wr_q <= wr_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign file_raddr_o = addr_s;
  assign file_wr_o = wr_q;
  assign w_o = w_q;
  assign neg_flag_o = n_q;
  assign zero_flag_o = z_q;
  assign phase_o = phase_q;
  assign nop_cycle_o = (flow_q != isx_pkg::ISX_RUN);
  assign instr_done_o = (phase_q == isx_pkg::ISX_WRITE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Phase steps
  // ----------------------------------------------------------------
  sequence decode_phase_s;
    phase_q == isx_pkg::ISX_DECODE;
  endsequence

  sequence read_phase_s;
    phase_q == isx_pkg::ISX_READ;
  endsequence

  sequence process_phase_s;
    phase_q == isx_pkg::ISX_PROCESS;
  endsequence

  sequence write_phase_s;
    phase_q == isx_pkg::ISX_WRITE;
  endsequence

  // ----------------------------------------------------------------
  // Phase and operand checks
  // ----------------------------------------------------------------
  phase_order_a: assert property (decode_phase_s |=> read_phase_s ##1 process_phase_s ##1 write_phase_s)
    else $error("phase order broken");
  inc_read_a: assert property ((read_phase_s and is_inc) |=> opnd_q == $past(file_rdata_i))
    else $error("operand read wrong");
  inc_result_a: assert property ((read_phase_s and is_inc) |=> ##1
    res_q == $past(file_rdata_i, 2) + isx_pkg::ONE) else $error("increment wrong");
  or_read_a: assert property ((read_phase_s and is_or) |=> opnd_q == $past(ir_q[7:0]))
    else $error("literal read wrong");
  or_result_a: assert property ((process_phase_s and is_or) |=>
    res_q == ($past(w_q) | $past(opnd_q))) else $error("OR value wrong");
  or_flags_a: assert property ((write_phase_s and is_or) |=> w_q == $past(res_q) &&
    z_q == (w_q == isx_pkg::ZERO) && n_q == w_q[7]) else $error("OR result wrong");

  // ----------------------------------------------------------------
  // Destination and skip checks
  // ----------------------------------------------------------------
  dest_file_a: assert property ((write_phase_s and (is_inc && ir_q[isx_pkg::DEST_BIT])) |=>
    wr_q.we && wr_q.data == $past(res_q) && $stable(w_q)) else $error("file write missing");
  dest_w_a: assert property ((write_phase_s and (is_inc && !ir_q[isx_pkg::DEST_BIT])) |=>
    !wr_q.we && w_q == $past(res_q)) else $error("W write missing");
  inc_flags_a: assert property ((write_phase_s and is_inc) |=> $stable(n_q) && $stable(z_q))
    else $error("increment touched flags");
  wr_addr_a: assert property ((write_phase_s and (is_inc && ir_q[isx_pkg::DEST_BIT])) |=>
    wr_q.addr == $past(addr_s.addr)) else $error("write address wrong");
  skip_nop_a: assert property ((write_phase_s and (is_inc && res_q != isx_pkg::ZERO)) |=>
    nop_cycle_o [*4] ##1 (nop_cycle_o == two_word_q)) else $error("skip wrong");
  no_skip_a: assert property ((write_phase_s and (is_inc && res_q == isx_pkg::ZERO)) |=> !nop_cycle_o)
    else $error("zero result skipped");
  skip_two_a: assert property ((write_phase_s and (flow_q == isx_pkg::ISX_FLUSH1 && two_word_q)) |=>
    flow_q == isx_pkg::ISX_FLUSH2) else $error("second NOP missing");
  skip_one_a: assert property ((write_phase_s and (flow_q == isx_pkg::ISX_FLUSH1 && !two_word_q)) |=>
    flow_q == isx_pkg::ISX_RUN) else $error("extra NOP inserted");
  skip_end_a: assert property ((write_phase_s and (flow_q == isx_pkg::ISX_FLUSH2)) |=>
    flow_q == isx_pkg::ISX_RUN) else $error("NOP run too long");
  nop_no_write_a: assert property (nop_cycle_o |-> !wr_d.we && w_d == w_q && n_d == n_q && z_d == z_q)
    else $error("NOP changed state");

  // ----------------------------------------------------------------
  // Address checks
  // ----------------------------------------------------------------
  access_low_a: assert property (!ir_q[isx_pkg::ACCESS_BIT] && !ext_set_en_i &&
    ir_q[7:0] < isx_pkg::ACCESS_SPLIT |-> addr_s.addr[11:8] == 4'h0) else $error("access bank wrong");
  access_high_a: assert property (!ir_q[isx_pkg::ACCESS_BIT] && ir_q[7:0] >= isx_pkg::ACCESS_SPLIT |->
    !addr_s.indexed && addr_s.addr[11:8] == isx_pkg::ACCESS_HI_BANK) else $error("upper access bank wrong");
  banked_a: assert property (ir_q[isx_pkg::ACCESS_BIT] |-> !addr_s.indexed &&
    addr_s.addr[11:8] == bank_select_register_i) else $error("bank select wrong");
  indexed_a: assert property (!ir_q[isx_pkg::ACCESS_BIT] && ext_set_en_i |->
    addr_s.indexed == (ir_q[7:0] <= isx_pkg::INDEXED_MAX)) else $error("indexed mode wrong");
endmodule : isx_core

// ==== pkg/isx_pkg.sv ====
package isx_pkg;
  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_INC_SKIP_NZ = 6'h12;
  localparam logic [7:0] OP_OR_LITERAL = 8'h09;
  localparam int OPC_HI = 15;
  localparam int OPC6_LO = 10;
  localparam int OPC8_LO = 8;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam logic [7:0] INDEXED_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO = 8'h00;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ISX_DECODE,
    ISX_READ,
    ISX_PROCESS,
    ISX_WRITE
  } isx_phase_type;

  typedef enum logic [1:0] {
    ISX_RUN,
    ISX_FLUSH1,
    ISX_FLUSH2
  } isx_flow_type;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } isx_file_wr_type;

  typedef struct packed {
    logic indexed;
    logic [11:0] addr;
  } isx_file_addr_type;
endpackage : isx_pkg

// ==== src/isx_addr_gen.sv ====
`timescale 1ns/1ps
module isx_addr_gen (
  input wire logic [7:0] file_i,
  input wire logic access_bit_i,
  input wire logic ext_set_en_i,
  input wire logic [3:0] bank_select_register_i,
  output isx_pkg::isx_file_addr_type addr_o
);
  // ----------------------------------------------------------------
  // File address: access bank, banked, or indexed literal offset
  // ----------------------------------------------------------------
  always_comb begin
    addr_o.indexed = 1'b0;
    addr_o.addr = {bank_select_register_i, file_i};
    if (!access_bit_i) begin
      if (ext_set_en_i && (file_i <= isx_pkg::INDEXED_MAX)) begin
        addr_o.indexed = 1'b1;
        addr_o.addr = {4'h0, file_i};
      end else if (file_i < isx_pkg::ACCESS_SPLIT) begin
        addr_o.addr = {4'h0, file_i};
      end else begin
        addr_o.addr = {isx_pkg::ACCESS_HI_BANK, file_i};
      end
    end
  end
endmodule : isx_addr_gen

// ==== verification/tb_increment_skip_or_literal_exec.sv ====
`timescale 1ns/1ps
module tb_increment_skip_or_literal_exec;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic next_two_word_i = 1'b0;
  logic ext_set_en_i = 1'b0;
  logic [3:0] bank_select_register_i = 4'h0;
  logic [7:0] file_rdata_i = 8'h00;
  isx_pkg::isx_file_addr_type file_raddr_o;
  isx_pkg::isx_file_wr_type file_wr_o;
  logic [7:0] w_o;
  logic neg_flag_o;
  logic zero_flag_o;
  logic [1:0] phase_o;
  logic nop_cycle_o;
  logic instr_done_o;
  int errors = 0;
  int checks = 0;
  int w_m = 0;
  int n_m = 0;
  int z_m = 0;
  int flush = 0;
  int first = 0;
  int i;
  int r;

  always #2.5 ref_clk_i = ~ref_clk_i;

  isx_core uut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .instr_i(instr_i),
    .next_two_word_i(next_two_word_i),
    .ext_set_en_i(ext_set_en_i),
    .bank_select_register_i(bank_select_register_i),
    .file_rdata_i(file_rdata_i),
    .file_raddr_o(file_raddr_o),
    .file_wr_o(file_wr_o),
    .w_o(w_o),
    .neg_flag_o(neg_flag_o),
    .zero_flag_o(zero_flag_o),
    .phase_o(phase_o),
    .nop_cycle_o(nop_cycle_o),
    .instr_done_o(instr_done_o)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  function automatic logic [12:0] exp_addr(logic [7:0] f, logic a, logic e, logic [3:0] b);
    if (e && !a && f <= isx_pkg::INDEXED_MAX) return {1'b1, 4'h0, f};
    if (!a) return {1'b0, (f < isx_pkg::ACCESS_SPLIT) ? 4'h0 : isx_pkg::ACCESS_HI_BANK, f};
    return {1'b0, b, f};
  endfunction : exp_addr

  // One instruction cycle, entered at a falling edge in phase 0
  task run(input logic [15:0] ins, input logic [7:0] rd, input logic tw, input logic e, input logic [3:0] b);
    int k;
    int fl;
    int inc;
    int orl;
    int res;
    logic [12:0] ad;
    instr_i = ins;
    file_rdata_i = rd;
    next_two_word_i = tw;
    ext_set_en_i = e;
    bank_select_register_i = b;
    fl = (flush > 0);
    inc = !fl && ins[15:10] == isx_pkg::OP_INC_SKIP_NZ;
    orl = !fl && ins[15:8] == isx_pkg::OP_OR_LITERAL;
    ad = exp_addr(ins[7:0], ins[8], e, b);
    res = (rd + 1) & 8'hFF;
    if (fl) begin
      flush = (first && tw) ? 1 : 0;
      first = 0;
    end
    for (k = 0; k < 4; k++) begin
      check(phase_o, k);
      check(instr_done_o, k == 3);
      check(nop_cycle_o, fl);
      if (inc && k == 1) check(file_raddr_o, ad);
      @(negedge ref_clk_i);
    end
    if (inc) begin
      if (!ins[9]) w_m = res;
      if (res != 0) begin
        flush = 1;
        first = 1;
      end
    end
    if (orl) begin
      w_m = w_m | ins[7:0];
      n_m = (w_m >> 7) & 1;
      z_m = (w_m == 0);
    end
    check(w_o, w_m);
    check({neg_flag_o, zero_flag_o}, {n_m[0], z_m[0]});
    check(file_wr_o.we, inc && ins[9]);
    if (inc && ins[9]) check({file_wr_o.addr, file_wr_o.data}, {ad[11:0], res[7:0]});
  endtask : run

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #100000;
    errors++;
    results;
  end

  initial begin
    r = $urandom(59);
    repeat (3) @(negedge ref_clk_i);
    check({w_o, neg_flag_o, zero_flag_o, file_wr_o.we, nop_cycle_o}, {isx_pkg::W_RESET, 4'h0});
    rst_n_i = 1'b1;
    run(16'h099A, 8'h00, 1'b0, 1'b0, 4'h0);
    run(16'h0935, 8'h00, 1'b0, 1'b0, 4'h0);
    run(16'h485F, 8'hFF, 1'b0, 1'b1, 4'h3);
    run(16'h4A60, 8'h12, 1'b0, 1'b1, 4'h3);
    run(16'h0901, 8'h00, 1'b1, 1'b0, 4'h0);
    run(16'h0902, 8'h00, 1'b0, 1'b0, 4'h0);
    run(16'h4B33, 8'h7F, 1'b0, 1'b0, 4'h5);
    run(16'h0904, 8'h00, 1'b0, 1'b0, 4'h0);
    run(16'h4A5F, 8'h00, 1'b0, 1'b1, 4'h1);
    run(16'h0000, 8'h00, 1'b0, 1'b0, 4'h0);
    for (i = 0; i < 300; i++) begin
      r = $urandom % 3;
      run(r == 0 ? {6'h12, 2'($urandom), 8'($urandom)} : r == 1 ? {8'h09, 8'($urandom)} : 16'($urandom),
          ($urandom % 4 == 0) ? 8'hFF : 8'($urandom), 1'($urandom), 1'($urandom), 4'($urandom));
    end
    results;
  end
endmodule : tb_increment_skip_or_literal_exec
